// File: psm_mode_select.sv
// Top of the program space mode select block: register access, mode decode and settle wait.
`timescale 1ns/1ps
// Behaviour
// - Bit 3 of the selection register at 1 selects compact mode, at 0 extended mode.
// - Compact mode forces program counter bit 14 to zero, limiting fetch to 16384 bytes.
// - A subroutine call pushes 2 stack bytes in compact mode and 3 in extended mode.
// - Absolute calls take 3 or 4 machine cycles and fixed-area calls 2 or 3, by mode.
// - The long branch and long call instructions run only in extended mode.
// - The register is written and read by 4-bit memory manipulation instructions.
// - Reset sets the mode bit to 1 so the core starts in compact mode.
// - The stack may sit in any of data memory banks 0 to 3 in both modes.
// - After reset the core waits 2^15 main clock periods before executing.
module psm_mode_select
	import psm_pkg::*;
#(
	parameter int SETTLE_COUNT = SETTLE_CYCLES
)(
	input  wire logic                 sys_clk,
	input  wire logic                 sys_rst,
	input  wire logic                 mem_wr_en,
	input  wire logic                 mem_rd_en,
	input  wire logic [SEL_WIDTH-1:0] mem_wr_data,
	output logic      [SEL_WIDTH-1:0] mem_rd_data,
	input  wire logic [PC_WIDTH-1:0]  pc_next,
	output logic      [PC_WIDTH-1:0]  pc_fetch,
	input  wire logic                 long_instr_decoded,
	output logic                      long_instr_allowed,
	output logic                      long_instr_illegal,
	output logic                      compact_mode,
	output logic                      extended_mode,
	output logic      [1:0]           stack_bank,
	output logic      [1:0]           stack_frame_bytes,
	output logic      [2:0]           call_cycles,
	output logic      [2:0]           fixed_area_call_cycles,
	output logic      [15:0]          rom_limit_bytes,
	output logic                      cpu_run
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		psm_state_type             state;
		logic [SETTLE_CNT_W-1:0]   cnt;
		logic [SEL_WIDTH-1:0]      rd_data;
	} psm_top_type;

	psm_top_type st_r;
	psm_top_type st_nxt;
	psm_reg_if   rif ();

	logic program_space_mode_bit;

	// ----------------------------------------------------------------
	// Register access
	// ----------------------------------------------------------------
	// Writes are held off during the settle wait because no instruction runs then.
	assign rif.wr_en   = mem_wr_en && cpu_run;
	assign rif.wr_data = mem_wr_data;

	psm_sel_reg u_sel (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.rif     (rif)
	);

	assign program_space_mode_bit = rif.value[MODE_BIT_POS];
	assign compact_mode  = (program_space_mode_bit == MODE_COMPACT);
	assign extended_mode = !compact_mode;
	assign stack_bank    = rif.value[BANK_LSB +: BANK_WIDTH];

	// ----------------------------------------------------------------
	// Mode-dependent figures
	// ----------------------------------------------------------------
	// Only the top bit is cut in compact mode, so code in the lower 16 Kbyte half runs unchanged.
	always_comb begin
		pc_fetch = pc_next;
		if (compact_mode) begin
			pc_fetch[PC_TOP_POS] = 1'b0;
		end
	end

	// The figures are plain decodes of the mode bit, so they change the cycle after a write.
	// Nothing here stops software from flipping the mode while calls are stacked.
	assign rom_limit_bytes        = compact_mode ? ROM_BYTES_CMP : ROM_BYTES_EXT;
	assign stack_frame_bytes      = compact_mode ? FRAME_CMP : FRAME_EXT;
	assign call_cycles            = compact_mode ? CALL_CYC_CMP : CALL_CYC_EXT;
	assign fixed_area_call_cycles = compact_mode ? FCALL_CYC_CMP : FCALL_CYC_EXT;
	assign long_instr_allowed     = extended_mode;
	assign long_instr_illegal     = long_instr_decoded && compact_mode;

	// ----------------------------------------------------------------
	// Settle wait and read path
	// ----------------------------------------------------------------
	// A read in the same cycle as a write returns the old value; the new one shows a cycle later.
	// The settle wait is fixed by a parameter, and software has no way to shorten it.
	always_comb begin
		st_nxt = st_r;
		if (mem_rd_en) begin
			st_nxt.rd_data = rif.value;
		end
		unique case (st_r.state)
			PSM_SETTLE: begin
				if (st_r.cnt == SETTLE_CNT_W'(SETTLE_COUNT - 1)) begin
					st_nxt.state = PSM_RUN;
				end else begin
					st_nxt.cnt = st_r.cnt + SETTLE_CNT_W'(1);
				end
			end
			PSM_RUN: begin
				st_nxt.cnt = st_r.cnt;
			end
			default: begin
				st_nxt.state = PSM_SETTLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st_r.state   <= PSM_SETTLE;
			st_r.cnt     <= '0;
			st_r.rd_data <= SEL_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign cpu_run     = (st_r.state == PSM_RUN);
	assign mem_rd_data = st_r.rd_data;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_mode_decode: assert property (@(posedge sys_clk) disable iff (sys_rst)
		compact_mode == rif.value[3])
		else $error("mode decode does not follow bit 3");
	a_pc_top_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
		compact_mode |-> pc_fetch[14] == 1'b0 && pc_fetch[13:0] == pc_next[13:0])
		else $error("pc top bit not held at zero in compact mode");
	a_frame_size: assert property (@(posedge sys_clk) disable iff (sys_rst)
		stack_frame_bytes == (compact_mode ? 2'h2 : 2'h3))
		else $error("stack frame size wrong for mode");
	a_call_timing: assert property (@(posedge sys_clk) disable iff (sys_rst)
		call_cycles == fixed_area_call_cycles + 3'h1 && call_cycles == (extended_mode ? 3'h4 : 3'h3))
		else $error("call timing wrong for mode");
	a_long_illegal: assert property (@(posedge sys_clk) disable iff (sys_rst)
		long_instr_decoded && compact_mode |-> long_instr_illegal && !long_instr_allowed)
		else $error("long instruction accepted in compact mode");
	a_write_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
		mem_wr_en && cpu_run ##1 mem_rd_en |=> mem_rd_data == $past(mem_wr_data, 2))
		else $error("register write not read back");
	a_stack_bank: assert property (@(posedge sys_clk) disable iff (sys_rst)
		mem_wr_en && cpu_run |=> stack_bank == $past(mem_wr_data[1:0]))
		else $error("stack bank does not follow low bits");
	a_settle_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$rose(cpu_run) |-> $past(st_r.cnt) == SETTLE_CNT_W'(SETTLE_COUNT - 1))
		else $error("execution started before settle wait ended");

	// ----------------------------------------------------------------
	// Decode checks
	// ----------------------------------------------------------------
	a_mode_pair: assert property (@(posedge sys_clk) disable iff (sys_rst)
		compact_mode != extended_mode)
		else $error("compact and extended mode flags agree");
	a_mode_follow_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!sys_rst && mem_wr_en && cpu_run |=> compact_mode == $past(mem_wr_data[3]))
		else $error("mode does not follow the written mode bit");
	a_pc_full_ext: assert property (@(posedge sys_clk) disable iff (sys_rst)
		extended_mode |-> pc_fetch == pc_next)
		else $error("program counter cut in extended mode");
	a_rom_limit: assert property (@(posedge sys_clk) disable iff (sys_rst)
		rom_limit_bytes == (compact_mode ? 16'h4000 : 16'h8000))
		else $error("program space size wrong for mode");
	a_frame_follow: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!sys_rst && mem_wr_en && cpu_run |=>
		stack_frame_bytes == ($past(mem_wr_data[3]) ? 2'h2 : 2'h3))
		else $error("stack frame size does not follow written mode");
	a_fcall_timing: assert property (@(posedge sys_clk) disable iff (sys_rst)
		fixed_area_call_cycles == (compact_mode ? 3'h2 : 3'h3))
		else $error("fixed area call timing wrong for mode");
	a_long_allowed: assert property (@(posedge sys_clk) disable iff (sys_rst)
		extended_mode |-> long_instr_allowed && !long_instr_illegal)
		else $error("long instruction refused in extended mode");
	a_long_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!long_instr_decoded |-> !long_instr_illegal)
		else $error("illegal flag raised without a long instruction");

	// ----------------------------------------------------------------
	// Register and settle checks
	// ----------------------------------------------------------------
	// Apart from a_reset_outputs and a_bank_decode, each antecedent excludes a sampled reset, so reset edges in mid-run do not trip them.
	// Some checks read the settle counter, so a counter fault shows even while cpu_run looks right.
	a_write_refused: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!sys_rst && mem_wr_en && !cpu_run |=> rif.value == $past(rif.value))
		else $error("register written during settle wait");
	a_read_capture: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!sys_rst && mem_rd_en |=> mem_rd_data == $past(rif.value))
		else $error("read data does not match register");
	a_read_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!sys_rst && !mem_rd_en |=> $stable(mem_rd_data))
		else $error("read data changed without a read");
	a_reg_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!sys_rst && !mem_wr_en |=> $stable(rif.value))
		else $error("register changed without a write");
	a_reset_outputs: assert property (@(posedge sys_clk)
		sys_rst |=> compact_mode && stack_bank == 2'h0 && !cpu_run && mem_rd_data == SEL_RESET)
		else $error("outputs not at reset values after reset");
	a_bank_decode: assert property (@(posedge sys_clk) disable iff (sys_rst)
		stack_bank == rif.value[1:0])
		else $error("stack bank does not follow register");
	a_run_stays: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!sys_rst && cpu_run |=> cpu_run)
		else $error("execution stopped without reset");
	a_no_early_run: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!sys_rst && !cpu_run && st_r.cnt != SETTLE_CNT_W'(SETTLE_COUNT - 1) |=> !cpu_run)
		else $error("execution started early");
	a_settle_count: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!sys_rst && !cpu_run && st_r.cnt != SETTLE_CNT_W'(SETTLE_COUNT - 1) |=>
		st_r.cnt == $past(st_r.cnt) + SETTLE_CNT_W'(1))
		else $error("settle counter skipped a step");
endmodule : psm_mode_select

// File: psm_pkg.sv
// Package of constants and types for the program space mode select block.
package psm_pkg;
	// ----------------------------------------------------------------
	// Register layout
	// ----------------------------------------------------------------
	localparam int          SEL_WIDTH       = 4;
	localparam int          MODE_BIT_POS    = 3;
	localparam int          BANK_LSB        = 0;
	localparam int          BANK_WIDTH      = 2;
	localparam logic [3:0]  SEL_RESET       = 4'h8;
	localparam logic        MODE_COMPACT    = 1'b1;
	// ----------------------------------------------------------------
	// Program counter and call figures
	// ----------------------------------------------------------------
	localparam int          PC_WIDTH        = 15;
	localparam int          PC_TOP_POS      = 14;
	localparam logic [15:0] ROM_BYTES_CMP   = 16'h4000;
	localparam logic [15:0] ROM_BYTES_EXT   = 16'h8000;
	localparam logic [1:0]  FRAME_CMP       = 2'h2;
	localparam logic [1:0]  FRAME_EXT       = 2'h3;
	localparam logic [2:0]  CALL_CYC_CMP    = 3'h3;
	localparam logic [2:0]  CALL_CYC_EXT    = 3'h4;
	localparam logic [2:0]  FCALL_CYC_CMP   = 3'h2;
	localparam logic [2:0]  FCALL_CYC_EXT   = 3'h3;
	// ----------------------------------------------------------------
	// Oscillation settling wait after reset, in main clock periods
	// ----------------------------------------------------------------
	localparam int          SETTLE_EXP      = 15;
	localparam int          SETTLE_CYCLES   = 1 << SETTLE_EXP;
	localparam int          SETTLE_CNT_W    = 16;

	typedef enum logic [1:0] {
		PSM_SETTLE,
		PSM_RUN
	} psm_state_type;
endpackage : psm_pkg

// File: psm_reg_if.sv
// Interface carrying the selection register between the top and its register cell.
`timescale 1ns/1ps
interface psm_reg_if;
	logic       wr_en;
	logic [3:0] wr_data;
	logic [3:0] value;
	modport owner (input wr_en, input wr_data, output value);
	modport user  (output wr_en, output wr_data, input value);
endinterface : psm_reg_if

// File: psm_sbs_reg.sv
// Four-bit stack bank selection register cell.
`timescale 1ns/1ps
module psm_sel_reg
	import psm_pkg::*;
(
	input  wire logic   sys_clk,
	input  wire logic   sys_rst,
	psm_reg_if.owner    rif
);
	typedef struct packed {
		logic [3:0] sel_r;
	} psm_cell_type;

	psm_cell_type st_r;
	psm_cell_type st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (rif.wr_en) begin
			st_nxt.sel_r = rif.wr_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st_r.sel_r <= SEL_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rif.value = st_r.sel_r;

	a_reset_compact: assert property (@(posedge sys_clk) sys_rst |=> st_r.sel_r[3] == 1'b1)
		else $error("mode bit not set to compact after reset");
endmodule : psm_sel_reg

// File: psm_mode_select_test.sv
// Self-checking testbench for the program space mode select block.
`timescale 1ns/1ps
module psm_mode_select_test
	import psm_pkg::*;
;
	localparam int SETTLE = 8;
	typedef struct packed {
		logic [3:0]  rd;
		logic [14:0] pc;
		logic        lng;
	} psm_note_type;
	logic         sys_clk            = 1'b0;
	logic         sys_rst            = 1'b1;
	logic         mem_wr_en          = 1'b0;
	logic         mem_rd_en          = 1'b0;
	logic [3:0]   mem_wr_data        = 4'h0;
	logic [14:0]  pc_next            = 15'h0;
	logic         long_instr_decoded = 1'b0;
	logic [3:0]   mem_rd_data;
	logic [14:0]  pc_fetch;
	logic         long_instr_allowed, long_instr_illegal, compact_mode, extended_mode, cpu_run;
	logic [1:0]   stack_bank, stack_frame_bytes;
	logic [2:0]   call_cycles, fixed_area_call_cycles;
	logic [15:0]  rom_limit_bytes;
	logic [31:0]  seed               = 32'hD9FE18B9;
	int           cyc                = 0;
	int           n_fail             = 0;
	int           samples_checked    = 0;
	psm_note_type notes[$];
	psm_note_type nt;

	psm_mode_select #(.SETTLE_COUNT(SETTLE)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.mem_wr_en(mem_wr_en), .mem_rd_en(mem_rd_en), .mem_wr_data(mem_wr_data),
		.mem_rd_data(mem_rd_data), .pc_next(pc_next), .pc_fetch(pc_fetch),
		.long_instr_decoded(long_instr_decoded), .long_instr_allowed(long_instr_allowed),
		.long_instr_illegal(long_instr_illegal), .compact_mode(compact_mode),
		.extended_mode(extended_mode), .stack_bank(stack_bank),
		.stack_frame_bytes(stack_frame_bytes), .call_cycles(call_cycles),
		.fixed_area_call_cycles(fixed_area_call_cycles),
		.rom_limit_bytes(rom_limit_bytes), .cpu_run(cpu_run));

	always #5 sys_clk = ~sys_clk;

	// Counts edges from reset release until the run flag is seen high.
	always @(posedge sys_clk) begin
		if (sys_rst) cyc <= 0;
		else if (!cpu_run) cyc <= cyc + 1;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
	endfunction : lfsr

	task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp

	// Write a value, read it back the next cycle and note what the read must show.
	task wr_rd(input logic [3:0] d, input logic [3:0] e);
		@(posedge sys_clk);
		seed = lfsr(seed);
		mem_wr_en <= 1'b1;
		mem_wr_data <= d;
		pc_next <= seed[14:0];
		long_instr_decoded <= seed[20];
		@(posedge sys_clk);
		mem_wr_en <= 1'b0;
		mem_rd_en <= 1'b1;
		notes.push_back('{e, pc_next, long_instr_decoded});
		@(posedge sys_clk);
		mem_rd_en <= 1'b0;
	endtask : wr_rd

	// Each read result is checked together with every decoded output it implies.
	always @(posedge sys_clk) begin
		if (mem_rd_en === 1'b1) begin
			#1;
			nt = notes.pop_front();
			cmp("read data", 16'(nt.rd), 16'(mem_rd_data));
			cmp("compact", 16'(nt.rd[3]), 16'(compact_mode));
			cmp("extended", 16'(!nt.rd[3]), 16'(extended_mode));
			cmp("bank", 16'(nt.rd[1:0]), 16'(stack_bank));
			cmp("frame", nt.rd[3] ? 16'h2 : 16'h3, 16'(stack_frame_bytes));
			cmp("call", nt.rd[3] ? 16'h3 : 16'h4, 16'(call_cycles));
			cmp("fcall", nt.rd[3] ? 16'h2 : 16'h3, 16'(fixed_area_call_cycles));
			cmp("rom", nt.rd[3] ? 16'h4000 : 16'h8000, rom_limit_bytes);
			cmp("pc", 16'({!nt.rd[3] & nt.pc[14], nt.pc[13:0]}), 16'(pc_fetch));
			cmp("long ok", 16'(!nt.rd[3]), 16'(long_instr_allowed));
			cmp("long bad", 16'(nt.rd[3] & nt.lng), 16'(long_instr_illegal));
		end
	end

	task report_and_stop;
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		repeat (2000) @(posedge sys_clk);
		n_fail++;
		report_and_stop();
	end

	initial begin
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		wr_rd(4'h0, SEL_RESET);
		repeat (SETTLE + 4) @(posedge sys_clk);
		cmp("settle", 16'(SETTLE), 16'(cyc));
		$display("test reset and settle done");
		for (int v = 0; v < 16; v++) begin
			wr_rd(4'(v ^ 5), 4'(v ^ 5));
		end
		repeat (16) begin
			wr_rd(seed[7:4], seed[7:4]);
		end
		$display("test all register values done");
		wr_rd(4'h3, 4'h3);
		@(posedge sys_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		wr_rd(4'h1, SEL_RESET);
		repeat (SETTLE + 4) @(posedge sys_clk);
		cmp("settle again", 16'(SETTLE), 16'(cyc));
		wr_rd(4'hB, 4'hB);
		repeat (2) @(posedge sys_clk);
		cmp("notes left", 16'h0, 16'(notes.size()));
		$display("test second reset done");
		report_and_stop();
	end
endmodule : psm_mode_select_test
